// File: sarsr_pkg.sv
// Shared constants and types for the converter serial readout ends.
package sarsr_pkg;
    localparam int RES_W = 16;
    localparam int MCLK_MHZ = 100;
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 1000;
    localparam int CONV_MIN_CYC = (CONV_MIN_NS * MCLK_MHZ) / 1000;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * MCLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = CONV_MIN_CYC / 2;
    localparam int SETUP_CYC = 4;
    localparam int SCK_HALF_CYC = 8;
    localparam logic RST_LOW = 1'b0;

    typedef enum logic [1:0] {
        SARSR_CS3,
        SARSR_CS4,
        SARSR_CHAIN
    } sarsr_mode_e;
endpackage

// File: sarsr_if.sv
// Serial link between the converter readout and its host.
`timescale 1ns/10ps
interface sarsr_if;
    logic convert_start_pin;
    logic serial_in_select;
    logic serial_shift_clock;
    logic serial_result_out;
    logic serial_result_oe;
    logic serial_result_line;

    // The line carries a pull-up, so a released output reads high.
    assign serial_result_line = serial_result_oe ? serial_result_out : 1'b1;

    modport dev (
        input  convert_start_pin,
        input  serial_in_select,
        input  serial_shift_clock,
        output serial_result_out,
        output serial_result_oe
    );

    modport host (
        output convert_start_pin,
        output serial_in_select,
        output serial_shift_clock,
        input  serial_result_line
    );
endinterface

// File: sarsr_dev.sv
// Converter end: conversion start, mode choice and serial result readout.
`timescale 1ns/10ps

module sarsr_dev #(
    parameter int RES_W    = sarsr_pkg::RES_W,
    parameter int CONV_CYC = sarsr_pkg::CONV_MAX_CYC
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    input  wire logic [RES_W-1:0] sample_i,
    output logic                  core_on_o,
    output logic                  chain_mode_o,
    output logic                  busy_mode_o,
    sarsr_if.dev                  link
);
    localparam int TW = $clog2(CONV_CYC + 1);
    localparam int CW = $clog2(RES_W + 2);

    typedef enum logic [2:0] {
        ST_ACQ,
        ST_CONV,
        ST_READY,
        ST_CHWAIT,
        ST_SHIFT
    } sarsr_dstate_e;

    // Link-domain logic: one toggle per falling clock edge while ce_i is high, plus the input bit.
    logic edge_tog;
    logic sdi_cap;

    always_ff @(negedge link.serial_shift_clock or negedge rst_b_i) begin
        if (rst_b_i == sarsr_pkg::RST_LOW) begin
            edge_tog <= 1'b0;
            sdi_cap  <= 1'b0;
        end else if (ce_i) begin
            edge_tog <= ~edge_tog;
            sdi_cap  <= link.serial_in_select;
        end
    end

    // Pin and cross-domain synchronisers.
    logic cnv_m, cnv_s, cnv_d;
    logic sdi_m, sdi_s;
    logic sck_m, sck_s;
    logic tog_m, tog_s, tog_d;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (rst_b_i == sarsr_pkg::RST_LOW) begin
            {cnv_m, cnv_s, cnv_d} <= 3'b000;
            // The select input idles high, so its synchroniser does too.
            {sdi_m, sdi_s}        <= 2'b11;
            {sck_m, sck_s}        <= 2'b00;
            {tog_m, tog_s, tog_d} <= 3'b000;
        end else if (ce_i) begin
            {cnv_m, cnv_s, cnv_d} <= {link.convert_start_pin, cnv_m, cnv_s};
            {sdi_m, sdi_s}        <= {link.serial_in_select, sdi_m};
            {sck_m, sck_s}        <= {link.serial_shift_clock, sck_m};
            {tog_m, tog_s, tog_d} <= {edge_tog, tog_m, tog_s};
        end
    end

    sarsr_dstate_e    state, next_state;
    logic [TW-1:0]    timer, next_timer;
    logic [CW-1:0]    bitcnt, next_bitcnt;
    logic [RES_W-1:0] sh, next_sh;
    logic             chain_mode, next_chain;
    logic             busy_mode, next_busy;
    logic             sdo_out, next_out;
    logic             sdo_oe, next_oe;

    wire cnv_rise = cnv_s & ~cnv_d;
    wire sck_fall = tog_s ^ tog_d;
    // Selected: start low in 3-wire use, or input low in 4-wire use.
    wire sel = ~(cnv_s & sdi_s);
    wire conv_end = (timer == TW'(CONV_CYC - 1));
    wire [CW-1:0] last_cnt = busy_mode ? CW'(RES_W) : CW'(RES_W - 1);
    wire last_fall = sck_fall & (bitcnt == last_cnt);

    always_comb begin
        next_state  = state;
        next_timer  = timer;
        next_bitcnt = bitcnt;
        next_sh     = sh;
        next_chain  = chain_mode;
        next_busy   = busy_mode;
        next_out    = sdo_out;
        next_oe     = sdo_oe;
        if (cnv_rise && state != ST_CONV) begin
            next_state  = ST_CONV;
            next_timer  = '0;
            next_bitcnt = '0;
            next_chain  = ~sdi_s;
            next_busy   = ~sdi_s & sck_s;
            next_oe     = ~sdi_s;
            next_out    = 1'b0;
        end else begin
            case (state)
                ST_ACQ: begin
                    next_out = 1'b0;
                    next_oe  = ~cnv_s & ~sdi_s;
                end
                ST_CONV: begin
                    next_timer = timer + TW'(1);
                    if (conv_end) begin
                        next_sh = sample_i;
                        if (!chain_mode) begin
                            next_busy = sel;
                            if (sel) begin
                                next_state = ST_SHIFT;
                                next_out   = 1'b0;
                                next_oe    = 1'b1;
                            end else begin
                                next_state = ST_READY;
                                next_oe    = 1'b0;
                            end
                        end else if (busy_mode) begin
                            next_state = ST_CHWAIT;
                            next_out   = 1'b0;
                        end else begin
                            next_state = ST_SHIFT;
                            next_out   = sample_i[RES_W-1];
                            next_sh    = {sample_i[RES_W-2:0], 1'b0};
                        end
                    end
                end
                ST_READY: begin
                    if (sel) begin
                        next_state = ST_SHIFT;
                        next_out   = sh[RES_W-1];
                        next_sh    = {sh[RES_W-2:0], 1'b0};
                        next_oe    = 1'b1;
                    end
                end
                ST_CHWAIT: begin
                    if (!cnv_s) begin
                        next_state = ST_ACQ;
                    end else if (sdi_s) begin
                        next_state = ST_SHIFT;
                        next_out   = 1'b1;
                    end
                end
                ST_SHIFT: begin
                    if (sck_fall) begin
                        next_out    = sh[RES_W-1];
                        next_sh     = {sh[RES_W-2:0], sdi_cap};
                        next_bitcnt = bitcnt + CW'(1);
                    end
                    if (chain_mode) begin
                        if (!cnv_s) begin
                            next_state = ST_ACQ;
                        end
                    end else if (!sel || last_fall) begin
                        next_state = ST_ACQ;
                        next_oe    = 1'b0;
                    end
                end
                default: begin
                    next_state = ST_ACQ;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (rst_b_i == sarsr_pkg::RST_LOW) begin
            state      <= ST_ACQ;
            timer      <= '0;
            bitcnt     <= '0;
            sh         <= '0;
            chain_mode <= 1'b0;
            busy_mode  <= 1'b0;
            sdo_out    <= 1'b0;
            sdo_oe     <= 1'b0;
            core_on_o  <= 1'b0;
        end else if (ce_i) begin
            state      <= next_state;
            timer      <= next_timer;
            bitcnt     <= next_bitcnt;
            sh         <= next_sh;
            chain_mode <= next_chain;
            busy_mode  <= next_busy;
            sdo_out    <= next_out;
            sdo_oe     <= next_oe;
            core_on_o  <= (next_state == ST_CONV);
        end
    end

    assign link.serial_result_out = sdo_out;
    assign link.serial_result_oe  = sdo_oe;
    assign chain_mode_o = chain_mode;
    assign busy_mode_o  = busy_mode;
endmodule

// File: sarsr_host.sv
// Host end: drives start, select and shift clock, and collects one result.
`timescale 1ns/10ps
module sarsr_host #(
    parameter int RES_W     = sarsr_pkg::RES_W,
    parameter int SCK_HALF  = sarsr_pkg::SCK_HALF_CYC,
    parameter int CONV_WAIT = sarsr_pkg::CONV_MAX_CYC,
    parameter int HOLD      = sarsr_pkg::HOLD_CYC
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   ce_i,
    input  wire logic                   start_i,
    input  wire sarsr_pkg::sarsr_mode_e mode_i,
    input  wire logic                   busy_i,
    output logic                        ready_o,
    output logic                        valid_o,
    output logic [RES_W-1:0]            data_o,
    sarsr_if.host                       link
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_CONV,
        H_WAIT,
        H_READ,
        H_DONE
    } sarsr_hstate_e;

    sarsr_hstate_e          st;
    sarsr_pkg::sarsr_mode_e mode;
    logic                   busy;
    logic [15:0]            tmr;
    logic [7:0]             nclk;
    logic [RES_W-1:0]       shreg;
    logic                   cnv, sdi, sck;
    logic                   sdo_m, sdo_s;

    wire is_chain = (mode == sarsr_pkg::SARSR_CHAIN);
    wire [7:0] total_clk = busy ? 8'(RES_W + 1) : 8'(RES_W);
    wire half_end = (tmr == 16'(SCK_HALF - 1));
    wire busy_seen = is_chain ? sdo_s : ~sdo_s;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (rst_b_i == sarsr_pkg::RST_LOW) begin
            {sdo_m, sdo_s} <= 2'b11;
        end else if (ce_i) begin
            {sdo_m, sdo_s} <= {link.serial_result_line, sdo_m};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (rst_b_i == sarsr_pkg::RST_LOW) begin
            st      <= H_IDLE;
            mode    <= sarsr_pkg::SARSR_CS3;
            busy    <= 1'b0;
            tmr     <= '0;
            nclk    <= '0;
            shreg   <= '0;
            cnv     <= 1'b0;
            sdi     <= 1'b1;
            sck     <= 1'b0;
            ready_o <= 1'b1;
            valid_o <= 1'b0;
            data_o  <= '0;
        end else if (ce_i) begin
            valid_o <= 1'b0;
            tmr     <= tmr + 16'd1;
            case (st)
                H_IDLE: begin
                    if (start_i) begin
                        st      <= H_SETUP;
                        mode    <= mode_i;
                        busy    <= busy_i;
                        ready_o <= 1'b0;
                        tmr     <= '0;
                        cnv     <= 1'b0;
                        sdi     <= (mode_i != sarsr_pkg::SARSR_CHAIN);
                        sck     <= (mode_i == sarsr_pkg::SARSR_CHAIN) & busy_i;
                    end
                end
                H_SETUP: begin
                    if (tmr == 16'(sarsr_pkg::SETUP_CYC - 1)) begin
                        st  <= H_CONV;
                        cnv <= 1'b1;
                        tmr <= '0;
                    end
                end
                H_CONV: begin
                    if (tmr == 16'(HOLD - 1)) begin
                        st  <= H_WAIT;
                        tmr <= '0;
                        sck <= 1'b0;
                        if (mode == sarsr_pkg::SARSR_CS3) begin
                            cnv <= ~busy;
                        end else if (mode == sarsr_pkg::SARSR_CS4) begin
                            sdi <= ~busy;
                        end else if (busy) begin
                            // With no upstream converter the host marks the chain as finished.
                            sdi <= 1'b1;
                        end
                    end
                end
                H_WAIT: begin
                    if (busy ? busy_seen : (tmr == 16'(CONV_WAIT - 1))) begin
                        st   <= H_READ;
                        tmr  <= '0;
                        nclk <= '0;
                        if (!busy && mode == sarsr_pkg::SARSR_CS3) begin
                            cnv <= 1'b0;
                        end else if (!busy && mode == sarsr_pkg::SARSR_CS4) begin
                            sdi <= 1'b0;
                        end
                    end
                end
                H_READ: begin
                    if (half_end) begin
                        tmr <= '0;
                        if (!sck) begin
                            sck   <= 1'b1;
                            shreg <= {shreg[RES_W-2:0], sdo_s};
                        end else begin
                            sck  <= 1'b0;
                            nclk <= nclk + 8'd1;
                            if (nclk == total_clk - 8'd1) begin
                                st <= H_DONE;
                            end
                        end
                    end
                end
                H_DONE: begin
                    st      <= H_IDLE;
                    valid_o <= 1'b1;
                    ready_o <= 1'b1;
                    data_o  <= shreg;
                    if (mode == sarsr_pkg::SARSR_CS4) begin
                        sdi <= 1'b1;
                    end else if (is_chain) begin
                        cnv <= 1'b0;
                    end
                end
                default: begin
                    st <= H_IDLE;
                end
            endcase
        end
    end

    assign link.convert_start_pin  = cnv;
    assign link.serial_in_select   = sdi;
    assign link.serial_shift_clock = sck;
endmodule

// File: sarsr_properties.sv
// Concurrent checks on the serial link between the host and converter ends.
`timescale 1ns/10ps
module sarsr_properties (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic convert_start_pin,
    input wire logic serial_in_select,
    input wire logic serial_shift_clock,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic core_on_o,
    input wire logic chain_mode_o,
    input wire logic busy_mode_o
);
    logic       sck_q;
    logic [3:0] fall_age;
    logic [3:0] next_fall_age;
    wire        sck_fall = sck_q && !serial_shift_clock;

    // Cycles since the last falling shift clock, saturating at fifteen.
    assign next_fall_age = sck_fall ? 4'h0 : (fall_age == 4'hF ? fall_age : fall_age + 4'h1);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_q    <= 1'b0;
            fall_age <= 4'hF;
        end else begin
            sck_q    <= serial_shift_clock;
            fall_age <= next_fall_age;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_start_select;
        $rose(convert_start_pin) && serial_in_select |-> ##[1:5] (!serial_result_oe && !chain_mode_o);
    endproperty
    a_start_select: assert property (p_start_select) else $error("select start wrong");

    property p_start_chain;
        $rose(convert_start_pin) && !serial_in_select && !serial_shift_clock
            |-> ##[1:5] (chain_mode_o && !busy_mode_o);
    endproperty
    a_start_chain: assert property (p_start_chain) else $error("chain start wrong");

    property p_conv_len;
        $rose(core_on_o) |-> core_on_o [*8] ##[1:16] !core_on_o;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    property p_busy_low;
        $fell(core_on_o) && !chain_mode_o && !(convert_start_pin && serial_in_select)
            |-> ##[0:2] (serial_result_oe && !serial_result_out);
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy bit missing");

    property p_chain_msb;
        $fell(core_on_o) && chain_mode_o && !busy_mode_o |-> ##[0:2] serial_result_oe;
    endproperty
    a_chain_msb: assert property (p_chain_msb) else $error("chain output not driven");

    property p_idle_low;
        (!convert_start_pin && !serial_in_select) [*3] |-> ##[0:3] (serial_result_oe && !serial_result_out);
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("idle output not low");

    property p_bit_stable;
        $changed(serial_result_out) && serial_result_oe && $past(serial_result_oe) && !chain_mode_o
            |-> fall_age <= 4'h6;
    endproperty
    a_bit_stable: assert property (p_bit_stable) else $error("data moved off clock fall");

    property p_sel_release;
        $rose(serial_in_select) && !chain_mode_o |-> ##[1:5] !serial_result_oe;
    endproperty
    a_sel_release: assert property (p_sel_release) else $error("deselect did not release");
endmodule

// File: sarsr_tb.sv
// Testbench joining the host end and the converter end across one serial link.
`timescale 1ns/10ps
module sarsr_tb;
    typedef struct packed {
        sarsr_pkg::sarsr_mode_e mode;
        logic                   busy;
        logic [15:0]            value;
    } sarsr_row_s;

    logic                   mclk_i      = 1'b0;
    logic                   rst_b_i     = 1'b0;
    logic                   ce          = 1'b1;
    logic                   start       = 1'b0;
    sarsr_pkg::sarsr_mode_e mode        = sarsr_pkg::SARSR_CS3;
    logic                   busy        = 1'b0;
    logic [15:0]            sample      = 16'h0000;
    logic                   core_on;
    logic                   chain_mode;
    logic                   busy_mode;
    logic                   ready;
    logic                   valid;
    logic [15:0]            data;
    int                     bad_count   = 0;
    int                     comparisons = 0;
    int                     falls       = 0;
    sarsr_row_s             rows [7]    = '{
        '{sarsr_pkg::SARSR_CS3,   1'b0, 16'hA5C3},
        '{sarsr_pkg::SARSR_CS3,   1'b1, 16'h8001},
        '{sarsr_pkg::SARSR_CS4,   1'b0, 16'h7FFE},
        '{sarsr_pkg::SARSR_CS4,   1'b1, 16'hFFFF},
        '{sarsr_pkg::SARSR_CHAIN, 1'b0, 16'h1234},
        '{sarsr_pkg::SARSR_CHAIN, 1'b1, 16'h6E91},
        '{sarsr_pkg::SARSR_CS3,   1'b0, 16'h0000}};

    sarsr_if link ();

    always #5 mclk_i = ~mclk_i;
    // Shift clock falls during a conversion are setup edges, not readout clocks.
    always @(negedge link.serial_shift_clock) begin
        if (core_on !== 1'b1) begin
            falls++;
        end
    end

    sarsr_dev #(.CONV_CYC(20)) i_sarsr_dev (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce), .sample_i(sample),
        .core_on_o(core_on), .chain_mode_o(chain_mode), .busy_mode_o(busy_mode), .link(link.dev));

    sarsr_host #(.CONV_WAIT(24), .HOLD(5)) i_sarsr_host (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce), .start_i(start), .mode_i(mode),
        .busy_i(busy), .ready_o(ready), .valid_o(valid), .data_o(data), .link(link.host));

    sarsr_properties i_sarsr_properties (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .convert_start_pin(link.convert_start_pin),
        .serial_in_select(link.serial_in_select), .serial_shift_clock(link.serial_shift_clock),
        .serial_result_out(link.serial_result_out), .serial_result_oe(link.serial_result_oe),
        .core_on_o(core_on), .chain_mode_o(chain_mode), .busy_mode_o(busy_mode));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One transfer; poke gives a refused extra start, freeze a ten-cycle stall of ce.
    task automatic run(input sarsr_row_s r, input int poke, input int freeze);
        int n;
        mode   <= r.mode;
        busy   <= r.busy;
        sample <= r.value;
        start  <= 1'b1;
        falls = 0;
        @(posedge mclk_i);
        for (n = 0; n < 2000 && valid !== 1'b1; n++) begin
            start <= (n == poke);
            ce    <= (n < freeze || n >= freeze + 10);
            @(posedge mclk_i);
        end
        if (n >= 2000) begin
            bad_count++;
            $display("ERROR %0t no result", $time);
            stop_test();
        end
        check(data, r.value, "result");
        check(16'(falls), r.busy ? 16'h0011 : 16'h0010, "clock count");
        check({13'h0000, chain_mode, busy_mode, core_on},
              {13'h0000, r.mode == sarsr_pkg::SARSR_CHAIN,
               r.busy, 1'b0}, "mode");
        $display("test done mode %0d busy %0d", r.mode, r.busy);
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i], -1, 9999);
        end
        // A start given mid-transfer is ignored, so the host stays idle afterwards.
        run(rows[0], 50, 9999);
        repeat (20) @(posedge mclk_i);
        check({15'h0000, ready}, 16'h0001, "refused start");
        $display("test done refused start");
        // Clock enable dropped during readout must not corrupt the result.
        run(rows[3], -1, 120);
        // Reset in mid-readout returns both ends to idle.
        start <= 1'b1;
        @(posedge mclk_i);
        start <= 1'b0;
        repeat (60) @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        check({12'h000, ready, valid, link.serial_result_oe, core_on}, 16'h0008, "reset state");
        $display("test done reset");
        rst_b_i <= 1'b1;
        run(rows[1], -1, 9999);
        stop_test();
    end
endmodule
